// ### rtd_pkg.sv
/*
 * constants for the register-transfer datapath: register offsets, field
 * positions, operation and addressing-mode codes, reset values.
 * assumes a classic wishbone slave with 32-bit data and byte addresses.
 */
package rtd_pkg;
   localparam int          WB_AW      = 8;
   localparam int          WB_DW      = 32;
   // register byte offsets
   localparam logic [7:0]  OFS_ACC    = 8'h00;
   localparam logic [7:0]  OFS_INDEX  = 8'h04;
   localparam logic [7:0]  OFS_STACK  = 8'h08;
   localparam logic [7:0]  OFS_PROG   = 8'h0c;
   localparam logic [7:0]  OFS_FLAGS  = 8'h10;
   localparam logic [7:0]  OFS_OPND   = 8'h14;
   localparam logic [7:0]  OFS_CMD    = 8'h18;
   localparam logic [7:0]  OFS_EADDR  = 8'h1c;
   localparam logic [7:0]  OFS_CYCLES = 8'h20;
   // condition flag bit positions
   localparam int          FL_C       = 0;
   localparam int          FL_Z       = 1;
   localparam int          FL_N       = 2;
   localparam int          FL_I       = 3;
   localparam int          FL_H       = 4;
   localparam int          FL_V       = 7;
   localparam logic [7:0]  FLAGS_MASK = 8'h9f;
   // reset values
   localparam logic [7:0]  RST_ACC    = 8'h00;
   localparam logic [15:0] RST_INDEX  = 16'h0000;
   localparam logic [15:0] RST_STACK  = 16'h00ff;
   localparam logic [15:0] RST_PROG   = 16'h0000;
   localparam logic [7:0]  RST_FLAGS  = 8'h08;
   // address arithmetic and decimal adjust
   localparam logic [15:0] PTR_STEP   = 16'h0001;
   localparam logic [15:0] BR_LEN     = 16'h0002;
   localparam logic [7:0]  DIRECT_HI  = 8'h00;
   localparam logic [3:0]  BCD_MAX    = 4'h9;
   localparam logic [7:0]  BCD_MAXB   = 8'h99;
   localparam logic [7:0]  ADJ_LO     = 8'h06;
   localparam logic [7:0]  ADJ_HI     = 8'h60;
   // command register fields
   localparam int          CMD_OP_LSB  = 0;
   localparam int          CMD_SEL_LSB = 4;
   typedef enum logic [3:0] {
      OP_NOP = 4'h0, OP_STK2IX = 4'h1, OP_IX2STK = 4'h2, OP_FL2ACC = 4'h3,
      OP_TAP = 4'h4, OP_ADD = 4'h5, OP_ADC = 4'h6, OP_SUB = 4'h7,
      OP_SBC = 4'h8, OP_DAA = 4'h9, OP_EA  = 4'ha, OP_BR  = 4'hb
   } rtd_op_t;
   typedef enum logic [3:0] {
      AM_INH  = 4'h0, AM_IMM  = 4'h1, AM_DIR  = 4'h2, AM_EXT  = 4'h3,
      AM_IX   = 4'h4, AM_IXP  = 4'h5, AM_IX1  = 4'h6, AM_IX1P = 4'h7,
      AM_IX2  = 4'h8, AM_STK1 = 4'h9, AM_STK2 = 4'ha, AM_REL  = 4'hb,
      AM_IMD  = 4'hc, AM_DD   = 4'hd, AM_IXPD = 4'he, AM_DIXP = 4'hf
   } rtd_mode_t;
   typedef enum logic [3:0] {
      BC_ALWAYS = 4'h0, BC_NEVER = 4'h1, BC_CC = 4'h2, BC_CS = 4'h3,
      BC_NE     = 4'h4, BC_EQ    = 4'h5, BC_PL = 4'h6, BC_MI = 4'h7,
      BC_VC     = 4'h8, BC_VS    = 4'h9
   } rtd_cond_t;
endpackage

// ### rtd_alu.sv
/*
 * 8-bit adder/subtractor with carry, half-carry, overflow, sign and zero.
 * assumes the caller registers the results; purely combinational.
 */
`timescale 1ns/1ns
module rtd_alu (
   input  wire logic       sub_i,   // 1 = subtract
   input  wire logic       cin_i,   // carry or borrow in
   input  wire logic [7:0] a_i,     // accumulator operand
   input  wire logic [7:0] b_i,     // memory operand
   output logic      [7:0] res_o,   // result
   output logic            c_o,     // carry out or borrow
   output logic            h_o,     // low nibble carry
   output logic            v_o,     // signed overflow
   output logic            n_o,     // result negative
   output logic            z_o      // result zero
);
   logic [8:0] wide;
   logic [4:0] nib;

   // sum or difference with carry into bit 8
   always_comb begin
      if (sub_i) begin
         wide = {1'b0, a_i} - {1'b0, b_i} - {8'h00, cin_i};
         nib  = {1'b0, a_i[3:0]} - {1'b0, b_i[3:0]} - {4'h0, cin_i};
         v_o  = (a_i[7] != b_i[7]) && (wide[7] != a_i[7]);
      end else begin
         wide = {1'b0, a_i} + {1'b0, b_i} + {8'h00, cin_i};
         nib  = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]} + {4'h0, cin_i};
         v_o  = (a_i[7] == b_i[7]) && (wide[7] != a_i[7]);
      end
      res_o = wide[7:0];
      c_o   = wide[8];
      h_o   = nib[4];
      n_o   = wide[7];
      z_o   = (wide[7:0] == 8'h00);
   end
endmodule

// ### rtd_datapath.sv
/*
 * register-transfer datapath: accumulator, index pair, stack pointer,
 * program counter and condition flags behind a classic wishbone slave.
 * writing the command register runs one transfer, arithmetic step,
 * address formation or branch decision in the cycle the write commits.
 * assumes one 50 mhz clock and a master that holds its request until ack.
 */
// Implementation choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ns
module rtd_datapath
   import rtd_pkg::*;
(
   input  wire logic                       clk_i,  // system clock
   input  wire logic                       rst_i,  // sync reset, high
   input  wire logic                       cyc_i,  // bus cycle
   input  wire logic                       stb_i,  // strobe
   input  wire logic                       we_i,   // write enable
   input  wire logic [3:0]                 sel_i,  // byte lanes
   input  wire logic [rtd_pkg::WB_AW-1:0]  adr_i,  // byte address
   input  wire logic [rtd_pkg::WB_DW-1:0]  dat_i,  // write data
   output logic                            ack_o,  // acknowledge
   output logic      [rtd_pkg::WB_DW-1:0]  dat_o   // read data
);
   import rtd_pkg::*;

   logic [7:0]  acc,    next_acc;
   logic [15:0] index,  next_index;
   logic [15:0] stack,  next_stack;
   logic [15:0] prog,   next_prog;
   logic [7:0]  flags,  next_flags;
   logic [15:0] opnd,   next_opnd;
   logic [7:0]  cmd,    next_cmd;
   logic [15:0] eaddr,  next_eaddr;
   logic [31:0] cycles, next_cycles;
   logic        ack,    next_ack;
   logic [31:0] rdat,   next_rdat;

   logic        req;
   logic        commit;
   logic [31:0] wmerge;
   logic [3:0]  op;
   logic [3:0]  fsel;
   logic        alu_sub;
   logic        alu_cin;
   logic [7:0]  alu_res;
   logic        alu_c;
   logic        alu_h;
   logic        alu_v;
   logic        alu_n;
   logic        alu_z;

   // sign extension of an 8-bit offset
   function automatic logic [15:0] sext8(input logic [7:0] v);
      return {{8{v[7]}}, v};
   endfunction

   // byte-lane merge of write data over a register image
   function automatic logic [31:0] lanes(input logic [31:0] old,
                                         input logic [31:0] wd,
                                         input logic [3:0]  be);
      logic [31:0] m;
      m = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            m[8*i +: 8] = wd[8*i +: 8];
         end
      end
      return m;
   endfunction

   function automatic logic [15:0] direct(input logic [7:0] lo);
      return {DIRECT_HI, lo};
   endfunction

   // branch condition over the flag byte
   function automatic logic taken(input logic [3:0] c, input logic [7:0] f);
      case (c)
         BC_ALWAYS: taken = 1'b1;
         BC_CC:     taken = ~f[FL_C];
         BC_CS:     taken = f[FL_C];
         BC_NE:     taken = ~f[FL_Z];
         BC_EQ:     taken = f[FL_Z];
         BC_PL:     taken = ~f[FL_N];
         BC_MI:     taken = f[FL_N];
         BC_VC:     taken = ~f[FL_V];
         BC_VS:     taken = f[FL_V];
         default:   taken = 1'b0;
      endcase
   endfunction

   assign req    = cyc_i & stb_i;
   assign commit = req & we_i & ack;
   assign op     = cmd_field(dat_i, CMD_OP_LSB);
   assign fsel   = cmd_field(dat_i, CMD_SEL_LSB);

   function automatic logic [3:0] cmd_field(input logic [31:0] d, input int lsb);
      return d[lsb +: 4];
   endfunction

   // operands for the shared adder
   always_comb begin
      alu_sub = (op == OP_SUB) || (op == OP_SBC);
      alu_cin = ((op == OP_ADC) || (op == OP_SBC)) ? flags[FL_C] : 1'b0;
   end

   rtd_alu u_alu (
      .sub_i (alu_sub),
      .cin_i (alu_cin),
      .a_i   (acc),
      .b_i   (opnd[7:0]),
      .res_o (alu_res),
      .c_o   (alu_c),
      .h_o   (alu_h),
      .v_o   (alu_v),
      .n_o   (alu_n),
      .z_o   (alu_z)
   );

   // bus answer: ack one cycle after the request, dropped after one cycle
   always_comb begin
      next_ack  = req & ~ack;
      next_rdat = rdat;
      wmerge    = 32'h0000_0000;
      if (req & ~ack) begin
         case (adr_i)
            OFS_ACC:    next_rdat = {24'h000000, acc};
            OFS_INDEX:  next_rdat = {16'h0000, index};
            OFS_STACK:  next_rdat = {16'h0000, stack};
            OFS_PROG:   next_rdat = {16'h0000, prog};
            OFS_FLAGS:  next_rdat = {24'h000000, flags & FLAGS_MASK};
            OFS_OPND:   next_rdat = {16'h0000, opnd};
            OFS_CMD:    next_rdat = {24'h000000, cmd};
            OFS_EADDR:  next_rdat = {16'h0000, eaddr};
            OFS_CYCLES: next_rdat = cycles;
            default:    next_rdat = 32'h0000_0000;
         endcase
      end
      case (adr_i)
         OFS_ACC:   wmerge = lanes({24'h000000, acc}, dat_i, sel_i);
         OFS_INDEX: wmerge = lanes({16'h0000, index}, dat_i, sel_i);
         OFS_STACK: wmerge = lanes({16'h0000, stack}, dat_i, sel_i);
         OFS_PROG:  wmerge = lanes({16'h0000, prog}, dat_i, sel_i);
         OFS_FLAGS: wmerge = lanes({24'h000000, flags}, dat_i, sel_i);
         OFS_OPND:  wmerge = lanes({16'h0000, opnd}, dat_i, sel_i);
         default:   wmerge = 32'h0000_0000;
      endcase
   end

   // datapath next values: direct writes and commanded operations
   always_comb begin
      next_acc    = acc;
      next_index  = index;
      next_stack  = stack;
      next_prog   = prog;
      next_flags  = flags;
      next_opnd   = opnd;
      next_cmd    = cmd;
      next_eaddr  = eaddr;
      next_cycles = cycles + 32'h0000_0001;
      if (commit) begin
         case (adr_i)
            OFS_ACC:   next_acc   = wmerge[7:0];
            OFS_INDEX: next_index = wmerge[15:0];
            OFS_STACK: next_stack = wmerge[15:0];
            OFS_PROG:  next_prog  = wmerge[15:0];
            OFS_FLAGS: next_flags = wmerge[7:0] & FLAGS_MASK;
            OFS_OPND:  next_opnd  = wmerge[15:0];
            OFS_CMD: begin
               if (sel_i[0]) begin
                  next_cmd = dat_i[7:0];
                  case (op)
                     OP_STK2IX: begin
                        next_index = stack + PTR_STEP;
                        next_stack = stack;
                     end
                     OP_IX2STK: begin
                        next_stack = index - PTR_STEP;
                     end
                     OP_FL2ACC: begin
                        next_acc   = flags & FLAGS_MASK;
                        next_flags = flags;
                     end
                     OP_TAP: next_flags = acc & FLAGS_MASK;
                     OP_ADD, OP_ADC, OP_SUB, OP_SBC: begin
                        next_acc          = alu_res;
                        next_flags[FL_C]  = alu_c;
                        next_flags[FL_V]  = alu_v;
                        next_flags[FL_N]  = alu_n;
                        next_flags[FL_Z]  = alu_z;
                        if (!alu_sub) begin
                           next_flags[FL_H] = alu_h;
                        end
                     end
                     OP_DAA: begin
                        next_acc = acc;
                        if (flags[FL_H] || (acc[3:0] > BCD_MAX)) begin
                           next_acc = next_acc + ADJ_LO;
                        end
                        if (flags[FL_C] || (acc > BCD_MAXB)) begin
                           next_acc         = next_acc + ADJ_HI;
                           next_flags[FL_C] = 1'b1;
                        end
                        next_flags[FL_N] = next_acc[7];
                        next_flags[FL_Z] = (next_acc == 8'h00);
                     end
                     OP_EA: begin
                        case (fsel)
                           AM_INH:  next_eaddr = 16'h0000;
                           AM_IMM:  next_eaddr = prog + PTR_STEP;
                           AM_DIR, AM_IMD, AM_DD, AM_IXPD:
                              next_eaddr = direct(opnd[7:0]);
                           AM_EXT:  next_eaddr = opnd;
                           AM_IX, AM_IXP, AM_DIXP: next_eaddr = index;
                           // 8-bit index and stack offsets are unsigned, zero-extended
                           AM_IX1, AM_IX1P: next_eaddr = index + {8'h00, opnd[7:0]};
                           AM_IX2:  next_eaddr = index + opnd;
                           AM_STK1: next_eaddr = stack + {8'h00, opnd[7:0]};
                           AM_STK2: next_eaddr = stack + opnd;
                           AM_REL:  next_eaddr = prog + BR_LEN + sext8(opnd[7:0]);
                           default: next_eaddr = 16'h0000;
                        endcase
                        if ((fsel == AM_IXP) || (fsel == AM_IX1P) ||
                            (fsel == AM_IXPD) || (fsel == AM_DIXP)) begin
                           next_index = index + PTR_STEP;
                        end
                     end
                     OP_BR: begin
                        // sequential when false, target when true
                        if (taken(fsel, flags)) begin
                           next_prog = prog + BR_LEN + sext8(opnd[7:0]);
                        end else begin
                           next_prog = prog + BR_LEN;
                        end
                        next_eaddr = next_prog;
                     end
                     default: next_cmd = dat_i[7:0];
                  endcase
               end
            end
            default: next_acc = acc;
         endcase
      end
   end

   // register stage for all state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         acc    <= RST_ACC;
         index  <= RST_INDEX;
         stack  <= RST_STACK;
         prog   <= RST_PROG;
         flags  <= RST_FLAGS;
         opnd   <= 16'h0000;
         cmd    <= 8'h00;
         eaddr  <= 16'h0000;
         cycles <= 32'h0000_0000;
         ack    <= 1'b0;
         rdat   <= 32'h0000_0000;
      end else begin
         acc    <= next_acc;
         index  <= next_index;
         stack  <= next_stack;
         prog   <= next_prog;
         flags  <= next_flags;
         opnd   <= next_opnd;
         cmd    <= next_cmd;
         eaddr  <= next_eaddr;
         cycles <= next_cycles;
         ack    <= next_ack;
         rdat   <= next_rdat;
      end
   end

   assign ack_o = ack;
   assign dat_o = rdat;
endmodule

// ### rtd_datapath_chk.sv
/* port checker for the register-transfer datapath.
   assumes it is bound to rtd_datapath and sees only its ports. */
`timescale 1ns/1ns
module rtd_datapath_chk
   import rtd_pkg::*;
(
   input wire logic        clk_i,  // system clock
   input wire logic        rst_i,  // sync reset
   input wire logic        cyc_i,  // bus cycle
   input wire logic        stb_i,  // strobe
   input wire logic        we_i,   // write enable
   input wire logic [3:0]  sel_i,  // byte lanes
   input wire logic [7:0]  adr_i,  // byte address
   input wire logic [31:0] dat_i,  // write data
   input wire logic        ack_o,  // acknowledge
   input wire logic [31:0] dat_o   // read data
);
   logic dir_seen;
   logic next_dir_seen;
   logic wr_ack;
   logic rd_ack;
   assign wr_ack = cyc_i && stb_i && we_i && ack_o;
   assign rd_ack = cyc_i && stb_i && !we_i && ack_o;
   // remembers whether the last command was 8'h2a, address formation in the direct mode
   always_comb begin
      next_dir_seen = dir_seen;
      if (wr_ack && adr_i == OFS_CMD && sel_i[0])
         next_dir_seen = (dat_i[7:0] == 8'h2a);
   end
   always_ff @(posedge clk_i) begin
      dir_seen <= rst_i ? 1'b0 : next_dir_seen;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   chk_ack_one_cycle: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("ack missing one cycle after request");
   chk_ack_single: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   chk_ack_cause: assert property (ack_o |-> $past(cyc_i) && $past(stb_i))
      else $error("ack without request");
   chk_flags_width: assert property (rd_ack && adr_i == OFS_FLAGS |->
      dat_o[31:8] == 24'h0 && dat_o[6:5] == 2'h0)
      else $error("flag read has stray bits");
   chk_acc_width: assert property (rd_ack && adr_i == OFS_ACC |-> dat_o[31:8] == 24'h0)
      else $error("accumulator wider than a byte");
   chk_ptr_width: assert property (rd_ack && (adr_i == OFS_STACK || adr_i == OFS_PROG)
      |-> dat_o[31:16] == 16'h0)
      else $error("pointer wider than 16 bits");
   chk_direct_page: assert property (rd_ack && adr_i == OFS_EADDR && dir_seen
      |-> dat_o[31:8] == 24'h0)
      else $error("direct address outside page zero");
   chk_read_hold: assert property (!(cyc_i && stb_i) |=> $stable(dat_o))
      else $error("read data changed without a read");
   cover property (wr_ack && adr_i == OFS_CMD);
   cover property (rd_ack && adr_i == OFS_EADDR && dir_seen);
   cover property (rd_ack && adr_i > OFS_CYCLES);
endmodule

// ### rtd_mem_model.sv
/* byte memory standing for the direct page of program and data memory.
   assumes writes on the rising edge and a combinational read. */
`timescale 1ns/1ns
module rtd_mem_model #(
   parameter int DEPTH = 256  // bytes modelled
) (
   input  wire logic        clk_i,  // bus clock
   input  wire logic        we_i,   // byte write
   input  wire logic [15:0] adr_i,  // byte address
   input  wire logic [7:0]  dat_i,  // write byte
   output logic      [7:0]  dat_o   // read byte
);
   logic [7:0] mem [DEPTH];
   // outside the array a changing pattern, never a stale byte
   always_comb begin
      dat_o = (adr_i < DEPTH) ? mem[adr_i] : {4{adr_i[0], ~adr_i[0]}};
   end
   always_ff @(posedge clk_i) begin
      if (we_i && adr_i < DEPTH) mem[adr_i] <= dat_i;
   end
endmodule

// ### rtd_datapath_tb_top.sv
/* self-checking bench for the register-transfer datapath.
   assumes rtd_pkg, rtd_datapath, the checker and the memory model. */
`timescale 1ns/1ns
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module rtd_datapath_tb_top;
   import rtd_pkg::*;
   logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, mem_we = 0;
   logic [3:0]  sel_i = 4'h0, op;
   logic [7:0]  adr_i = 8'h00, acc, fl, a, b, mem_dat, mem_wd = 8'h00;
   logic [8:0]  s;
   logic [15:0] v, ix, pexp, mem_adr = 16'h0;
   logic [31:0] dat_i = 32'h0, dat_o, rd, r, t0, c1, l1, cnt = 0, seed = 32'd76126;
   logic        ack_o, ci;
   int          fails = 0, comparisons = 0;
   logic [15:0] rv [8] = '{16'h00, 16'h0, 16'h00ff, 16'h0, 16'h08, 16'h0, 16'h00, 16'h0};
   rtd_datapath DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .sel_i(sel_i), .adr_i(adr_i), .dat_i(dat_i), .ack_o(ack_o), .dat_o(dat_o));
   rtd_mem_model #(.DEPTH(256)) mem (.clk_i(clk_i), .we_i(mem_we), .adr_i(mem_adr),
      .dat_i(mem_wd), .dat_o(mem_dat));
   // clock and bench cycle count
   always #10 clk_i = ~clk_i;
   always @(posedge clk_i) cnt <= cnt + 1;
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // one classic cycle, held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] ad, input logic [3:0] sl,
                     input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= ad;
      sel_i <= sl;
      dat_i <= d;
      t0 = cnt;
      do begin @(posedge clk_i); n++; end while (ack_o !== 1'b1 && n < 20);
      if (n >= 20) begin
         fails++;
         give_verdict();
      end
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      wb(1'b1, ad, 4'hf, d);
   endtask
   task automatic rdr(input logic [7:0] ad);
      wb(1'b0, ad, 4'hf, 32'h0);
   endtask
   task automatic give_verdict();
      $display("comparisons=%0d fails=%0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk_i);
      fails++;
      give_verdict();
   end
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int k = 0; k < 8; k++) begin
         rdr(8'(k * 4));
         `CHK(rd, {16'h0, rv[k]})
      end
      // fill the direct page of the memory model
      for (int k = 0; k < 256; k++) begin
         r = xs();
         @(posedge clk_i);
         mem_we <= 1'b1;
         mem_adr <= 16'(k);
         mem_wd <= r[7:0];
      end
      @(posedge clk_i);
      mem_we <= 1'b0;
      for (int k = 0; k < 4; k++) begin
         r = xs();
         wr(OFS_ACC, {24'h0, r[7:0]});
         wr(OFS_CMD, 32'h04);
         fl = r[7:0] & FLAGS_MASK;
         wr(OFS_CMD, 32'h03);
         rdr(OFS_ACC);
         `CHK(rd, {24'h0, fl})
         rdr(OFS_FLAGS);
         `CHK(rd, {24'h0, fl})
      end
      for (int i = 0; i < 16; i++) begin
         r = xs();
         a = r[15:8];
         op = 4'h5 + 4'(i % 4);
         wr(OFS_OPND, {16'h0, r[31:24], r[7:0]});
         wr(OFS_CMD, 32'h2a);
         rdr(OFS_EADDR);
         `CHK(rd, {24'h0, r[7:0]})
         mem_adr <= {8'h00, r[7:0]};
         #1 b = mem_dat;
         wr(OFS_OPND, {24'h0, b});
         wr(OFS_ACC, {24'h0, a});
         wr(OFS_CMD, {28'h0, op});
         ci = (op == 4'h6 || op == 4'h8) ? fl[FL_C] : 1'b0;
         s = (op < 4'h7) ? {1'b0, a} + {1'b0, b} + 9'(ci) : {1'b0, a} - {1'b0, b} - 9'(ci);
         if (op < 4'h7) begin
            fl[FL_H] = ({1'b0, a[3:0]} + {1'b0, b[3:0]} + 5'(ci)) > 5'd15;
            fl[FL_V] = (a[7] == b[7]) && (s[7] != a[7]);
         end else fl[FL_V] = (a[7] != b[7]) && (s[7] != a[7]);
         fl[FL_C] = s[8];
         fl[FL_Z] = (s[7:0] == 8'h00);
         fl[FL_N] = s[7];
         rdr(OFS_ACC);
         `CHK(rd, {24'h0, s[7:0]})
         rdr(OFS_FLAGS);
         `CHK(rd, {24'h0, fl})
      end
      // decimal adjust from half-carry, carry and the two nibbles
      for (int k = 0; k < 4; k++) begin
         r = xs();
         a = r[7:0];
         fl = r[15:8] & FLAGS_MASK;
         wr(OFS_ACC, {24'h0, a});
         wr(OFS_FLAGS, {24'h0, fl});
         wr(OFS_CMD, 32'h09);
         b = a;
         if (fl[FL_H] || a[3:0] > 4'h9) b = b + 8'h06;
         if (fl[FL_C] || a > 8'h99) begin
            b = b + 8'h60;
            fl[FL_C] = 1'b1;
         end
         fl[FL_N] = b[7];
         fl[FL_Z] = (b == 8'h00);
         rdr(OFS_ACC);
         `CHK(rd, {24'h0, b})
         rdr(OFS_FLAGS);
         `CHK(rd, {24'h0, fl})
      end
      for (int k = 0; k < 4; k++) begin
         r = xs();
         wr(OFS_ACC, {31'h0, r[0]});
         wr(OFS_CMD, 32'h04);
         fl = {7'h0, r[0]};
         rdr(OFS_PROG);
         pexp = rd[15:0] + BR_LEN;
         if (k[0] == r[0]) pexp = pexp + {{8{r[15]}}, r[15:8]};
         wr(OFS_OPND, {16'h0, r[23:8]});
         wr(OFS_CMD, {24'h0, 4'h2 + 4'(k % 2), 4'hb});
         rdr(OFS_PROG);
         `CHK(rd, {16'h0, pexp})
      end
      for (int k = 0; k < 3; k++) begin
         r = xs();
         v = (k == 0) ? 16'hffff : (k == 1) ? 16'h0000 : r[15:0];
         wr(OFS_STACK, {16'h0, v});
         wr(OFS_CMD, 32'h01);
         rdr(OFS_INDEX);
         `CHK(rd, {16'h0, 16'(v + 16'h0001)})
         rdr(OFS_STACK);
         `CHK(rd, {16'h0, v})
         rdr(OFS_FLAGS);
         `CHK(rd, {24'h0, fl})
         wr(OFS_INDEX, {16'h0, v});
         wr(OFS_CMD, 32'h02);
         rdr(OFS_STACK);
         `CHK(rd, {16'h0, 16'(v - 16'h0001)})
      end
      r = xs();
      ix = r[15:0];
      wr(OFS_INDEX, {16'h0, ix});
      wr(OFS_OPND, {16'h0, r[31:16]});
      for (int k = 0; k < 3; k++) begin
         wr(OFS_CMD, 32'h4a + 32'(k * 32));
         rdr(OFS_EADDR);
         v = (k == 0) ? ix : (k == 1) ? ix + {8'h0, r[23:16]} : ix + r[31:16];
         `CHK(rd, {16'h0, v})
      end
      // refused writes: unmapped place and command without its lane
      wr(8'h40, xs());
      rdr(8'h40);
      `CHK(rd, 32'h0)
      wr(OFS_STACK, 32'h1234);
      wb(1'b1, OFS_CMD, 4'he, 32'h01);
      rdr(OFS_INDEX);
      `CHK(rd, {16'h0, ix})
      // post-increment and stack-relative address forms
      wr(OFS_CMD, 32'h7a);
      rdr(OFS_EADDR);
      `CHK(rd, {16'h0, 16'(ix + {8'h0, r[23:16]})})
      rdr(OFS_INDEX);
      `CHK(rd, {16'h0, 16'(ix + 16'h0001)})
      wr(OFS_CMD, 32'haa);
      rdr(OFS_EADDR);
      `CHK(rd, {16'h0, 16'(16'h1234 + r[31:16])})
      // mid-run reset brings the eight registers at offsets 0x00 to 0x1c back to their reset values
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int k = 0; k < 8; k++) begin
         rdr(8'(k * 4));
         `CHK(rd, {16'h0, rv[k]})
      end
      rdr(OFS_CYCLES);
      c1 = rd;
      l1 = t0;
      repeat (7) @(posedge clk_i);
      rdr(OFS_CYCLES);
      `CHK(rd - c1, t0 - l1)
      give_verdict();
   end
endmodule
bind rtd_datapath rtd_datapath_chk chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
   .stb_i(stb_i), .we_i(we_i), .sel_i(sel_i), .adr_i(adr_i), .dat_i(dat_i),
   .ack_o(ack_o), .dat_o(dat_o));
